/* File: ssp_defines.svh */
// Constants for the serial programming and power-down front end
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

`define SSP_WORD_W        24
`define SSP_NUM_LATCH     8
`define SSP_SYNC_STAGES   2
`define SSP_LATCH_RST     24'h000000
`define SSP_CNT_W         16

// Address field
`define SSP_ADDR_BIT0     0
`define SSP_ADDR_HI_MSB   3
`define SSP_ADDR_HI_LSB   1
`define SSP_IDX_DIV       3'h0
`define SSP_IDX_MAIN_REF  3'h1
`define SSP_IDX_AUX_DIV   3'h2
`define SSP_IDX_MODE      3'h4

// Main divider word
`define SSP_R0_N_MSB      23
`define SSP_R0_N_LSB      13
`define SSP_R0_FN_MSB     12
`define SSP_R0_FN_LSB     1
// Main reference and denominator
`define SSP_R1_PD_BIT     23
`define SSP_R1_P_BIT      22
`define SSP_R1_R_MSB      21
`define SSP_R1_R_LSB      16
`define SSP_R1_FD_MSB     15
`define SSP_R1_FD_LSB     4
// Aux divider word
`define SSP_R2_PD_BIT     23
`define SSP_R2_N_MSB      22
`define SSP_R2_N_LSB      4
// Aux reference and pump gain
`define SSP_R3_CPG_MSB    19
`define SSP_R3_CPG_LSB    16
`define SSP_R3_R_MSB      15
`define SSP_R3_R_LSB      4
// Mode control
`define SSP_R4_AUTO_POWERUP_ON_DIVIDER_WRITE_BIT   23
// Extended fraction
`define SSP_R5_FD_MSB     23
`define SSP_R5_FD_LSB     14
`define SSP_R5_FN_MSB     13
`define SSP_R5_FN_LSB     4
// Fast-lock timeout
`define SSP_R6_TOC_MSB    17
`define SSP_R6_TOC_LSB    4
// Test and reset control
`define SSP_R7_AUX_RST    7
`define SSP_R7_MAIN_RST   6

`endif

/* File: ssp_pkg.sv */
// Types shared by the serial programming front end
`default_nettype none
`include "ssp_defines.svh"
package ssp_pkg;
    typedef logic [`SSP_WORD_W-1:0] ssp_word_t;
    typedef logic [2:0]             ssp_idx_t;

    typedef struct packed {
        ssp_word_t [`SSP_NUM_LATCH-1:0] bank;
        logic [`SSP_NUM_LATCH-1:0]      wr_pulse;
        logic [`SSP_NUM_LATCH-1:0]      written;
        logic                           le_q;
        logic                           auto_powerup_on_divider_write_hold;
        logic                           main_pd;
        logic                           aux_pd;
        logic                           lock_clr;
        logic                           fast_clr;
        ssp_idx_t                       last_idx;
        logic [`SSP_CNT_W-1:0]          word_count;
    } ssp_core_t;
endpackage : ssp_pkg
`default_nettype wire

/* File: ssp_link_if.sv */
// Carrier between the link-side shifter and the core
`timescale 1ns/100ps
`default_nettype none
interface ssp_link_if;
    import ssp_pkg::*;
    ssp_word_t word;

    modport shifter (output word);
    modport core    (input  word);
endinterface : ssp_link_if
`default_nettype wire

/* File: ssp_sync.sv */
// Two-stage level synchroniser into the core clock
`timescale 1ns/100ps
`default_nettype none
module ssp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    // Levels
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ssp_sync_st_t;

    ssp_sync_st_t st_ff;
    ssp_sync_st_t nxt_st;

    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = i_d;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_q = st_ff.s2;
endmodule : ssp_sync
`default_nettype wire

/* File: ssp_shift.sv */
// Link-clock input shift register
`timescale 1ns/100ps
`default_nettype none
`include "ssp_defines.svh"
module ssp_shift
    import ssp_pkg::*;
(
    // Link clock and reset
    input  wire logic   i_sclk,
    input  wire logic   i_arst_n,
    // Serial data, synchronous to the link clock
    input  wire logic   i_sdata,
    // Assembled word
    ssp_link_if.shifter link
);
    typedef struct packed {
        ssp_word_t sr;
    } ssp_shift_st_t;

    ssp_shift_st_t st_ff;
    ssp_shift_st_t nxt_st;

    // Oldest bit walks to bit 23; older bits fall off the top
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.sr = {st_ff.sr[`SSP_WORD_W-2:0], i_sdata};
    end

    always_ff @(posedge i_sclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.word = st_ff.sr;
endmodule : ssp_shift
`default_nettype wire

/* File: ssp_top.sv */
// Serial programming latch bank and power-down control
`timescale 1ns/100ps
`default_nettype none
`include "ssp_defines.svh"
module ssp_top
    import ssp_pkg::*;
(
    // Core clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_arst_n,
    // Serial link
    input  wire logic                      i_sclk,
    input  wire logic                      i_sdata,
    input  wire logic                      i_latch_strobe,
    // Chip enable pin
    input  wire logic                      i_chip_enable,
    // Power state
    output logic                           o_main_powered_down,
    output logic                           o_aux_powered_down,
    // Counter restarts
    output logic                           o_lock_detect_clear,
    output logic                           o_fastlock_clear,
    // Write activity
    output logic [`SSP_NUM_LATCH-1:0]      o_latch_write,
    output logic [`SSP_NUM_LATCH-1:0]      o_latch_written,
    output logic [2:0]                     o_last_address,
    output logic [`SSP_CNT_W-1:0]          o_word_count,
    // Main divider fields
    output logic [10:0]                    o_main_integer_divider,
    output logic [11:0]                    o_main_frac_numerator,
    // Main reference fields
    output logic                           o_main_synth_powerdown,
    output logic                           o_main_prescaler_select,
    output logic [5:0]                     o_main_reference_divider,
    output logic [11:0]                    o_main_frac_denominator,
    // Aux fields and main pump gain
    output logic                           o_aux_synth_powerdown,
    output logic [18:0]                    o_aux_integer_divider,
    output logic [3:0]                     o_main_pump_gain,
    output logic [11:0]                    o_aux_reference_divider,
    // Mode, extension, fast-lock timeout and counter reset fields
    output logic                           o_auto_powerup_on_divider_write,
    output logic [9:0]                     o_main_frac_denominator_ext,
    output logic [9:0]                     o_main_frac_numerator_ext,
    output logic [13:0]                    o_fastlock_timeout_count,
    output logic                           o_aux_counter_reset,
    output logic                           o_main_counter_reset,
    // Raw latch words
    output ssp_word_t [`SSP_NUM_LATCH-1:0] o_latch_bank
);
    localparam int SYNC_W = `SSP_WORD_W + 2;

    ssp_link_if  link ();

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    ssp_word_t         word_s;
    logic              le_s;
    logic              ce_s;

    ssp_core_t         st_ff;
    ssp_core_t         nxt_st;

    // Link-side shifting
    ssp_shift u_shift (
        .i_sclk   (i_sclk),
        .i_arst_n (i_arst_n),
        .i_sdata  (i_sdata),
        .link     (link.shifter)
    );

    // The word is static while the strobe is high, so it crosses
    // beside the strobe and is only taken after the strobe edge
    assign sync_in = {i_chip_enable, i_latch_strobe, link.word};

    ssp_sync #(
        .W (SYNC_W)
    ) u_sync (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_d      (sync_in),
        .o_q      (sync_out)
    );

    assign ce_s   = sync_out[SYNC_W-1];
    assign le_s   = sync_out[SYNC_W-2];
    assign word_s = sync_out[`SSP_WORD_W-1:0];

    // Target latch decode of the low four bits
    function automatic logic addr_valid(input ssp_word_t w);
        logic ok;
        ok = 1'b1;
        if (w[`SSP_ADDR_BIT0] && (w[`SSP_ADDR_HI_MSB:`SSP_ADDR_HI_LSB] == `SSP_IDX_DIV)) begin
            ok = 1'b0;
        end
        return ok;
    endfunction : addr_valid

    function automatic ssp_idx_t addr_index(input ssp_word_t w);
        ssp_idx_t idx;
        idx = `SSP_IDX_DIV;
        if (w[`SSP_ADDR_BIT0]) begin
            idx = w[`SSP_ADDR_HI_MSB:`SSP_ADDR_HI_LSB];
        end
        return idx;
    endfunction : addr_index

    always_comb begin
        logic     le_rise;
        logic     take;
        ssp_idx_t idx;
        le_rise = 1'b0;
        take    = 1'b0;
        idx     = `SSP_IDX_DIV;

        nxt_st          = st_ff;
        nxt_st.le_q     = le_s;
        nxt_st.wr_pulse = '0;
        nxt_st.lock_clr = 1'b0;
        nxt_st.fast_clr = 1'b0;

        le_rise = le_s && !st_ff.le_q;
        idx     = addr_index(word_s);
        take    = le_rise && addr_valid(word_s);

        if (take) begin
            nxt_st.bank[idx]     = word_s;
            nxt_st.wr_pulse[idx] = 1'b1;
            nxt_st.written[idx]  = 1'b1;
            nxt_st.last_idx      = idx;
            nxt_st.word_count    = st_ff.word_count + `SSP_CNT_W'(1);
            if (idx == `SSP_IDX_DIV) begin
                // Counters restart, their programmed values stay
                nxt_st.lock_clr = 1'b1;
                nxt_st.fast_clr = 1'b1;
                if (st_ff.bank[`SSP_IDX_MODE][`SSP_R4_AUTO_POWERUP_ON_DIVIDER_WRITE_BIT]) begin
                    nxt_st.auto_powerup_on_divider_write_hold = 1'b1;
                end
            end
            // A fresh main power-down request retires the auto power-up
            if ((idx == `SSP_IDX_MAIN_REF) && word_s[`SSP_R1_PD_BIT]) begin
                nxt_st.auto_powerup_on_divider_write_hold = 1'b0;
            end
        end

        if (!ce_s) begin
            nxt_st.auto_powerup_on_divider_write_hold = 1'b0;
        end

        // Chip enable dominates, then auto power-up (main only), then the section bits
        nxt_st.main_pd = !ce_s
                       || (nxt_st.bank[`SSP_IDX_MAIN_REF][`SSP_R1_PD_BIT]
                           && !nxt_st.auto_powerup_on_divider_write_hold);
        nxt_st.aux_pd  = !ce_s
                       || nxt_st.bank[`SSP_IDX_AUX_DIV][`SSP_R2_PD_BIT];
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_ff            <= '0;
            st_ff.bank       <= {`SSP_NUM_LATCH{`SSP_LATCH_RST}};
            st_ff.main_pd    <= 1'b1;
            st_ff.aux_pd     <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Power state and activity
    assign o_main_powered_down = st_ff.main_pd;
    assign o_aux_powered_down  = st_ff.aux_pd;
    assign o_lock_detect_clear = st_ff.lock_clr;
    assign o_fastlock_clear    = st_ff.fast_clr;
    assign o_latch_write       = st_ff.wr_pulse;
    assign o_latch_written     = st_ff.written;
    assign o_last_address      = st_ff.last_idx;
    assign o_word_count        = st_ff.word_count;
    assign o_latch_bank        = st_ff.bank;

    // Field views of the latches
    assign o_main_integer_divider = st_ff.bank[0][`SSP_R0_N_MSB:`SSP_R0_N_LSB];
    assign o_main_frac_numerator  = st_ff.bank[0][`SSP_R0_FN_MSB:`SSP_R0_FN_LSB];

    assign o_main_synth_powerdown   = st_ff.bank[1][`SSP_R1_PD_BIT];
    assign o_main_prescaler_select  = st_ff.bank[1][`SSP_R1_P_BIT];
    assign o_main_reference_divider = st_ff.bank[1][`SSP_R1_R_MSB:`SSP_R1_R_LSB];
    assign o_main_frac_denominator  = st_ff.bank[1][`SSP_R1_FD_MSB:`SSP_R1_FD_LSB];

    assign o_aux_synth_powerdown   = st_ff.bank[2][`SSP_R2_PD_BIT];
    assign o_aux_integer_divider   = st_ff.bank[2][`SSP_R2_N_MSB:`SSP_R2_N_LSB];
    assign o_main_pump_gain        = st_ff.bank[3][`SSP_R3_CPG_MSB:`SSP_R3_CPG_LSB];
    assign o_aux_reference_divider = st_ff.bank[3][`SSP_R3_R_MSB:`SSP_R3_R_LSB];

    assign o_auto_powerup_on_divider_write = st_ff.bank[4][`SSP_R4_AUTO_POWERUP_ON_DIVIDER_WRITE_BIT];
    assign o_main_frac_denominator_ext = st_ff.bank[5][`SSP_R5_FD_MSB:`SSP_R5_FD_LSB];
    assign o_main_frac_numerator_ext   = st_ff.bank[5][`SSP_R5_FN_MSB:`SSP_R5_FN_LSB];
    assign o_fastlock_timeout_count = st_ff.bank[6][`SSP_R6_TOC_MSB:`SSP_R6_TOC_LSB];
    assign o_aux_counter_reset  = st_ff.bank[7][`SSP_R7_AUX_RST];
    assign o_main_counter_reset = st_ff.bank[7][`SSP_R7_MAIN_RST];
endmodule : ssp_top
`default_nettype wire

/* File: ssp_props.sv */
// Assertion checker for the serial programming front end
`timescale 1ns/100ps
`default_nettype none
`include "ssp_defines.svh"
module ssp_props
    import ssp_pkg::*;
(
    // Clock, reset and pins
    input wire logic                      i_clk,
    input wire logic                      i_arst_n,
    input wire logic                      i_chip_enable,
    // Observed outputs
    input wire logic                      o_main_powered_down,
    input wire logic                      o_aux_powered_down,
    input wire logic                      o_lock_detect_clear,
    input wire logic                      o_fastlock_clear,
    input wire logic [`SSP_NUM_LATCH-1:0] o_latch_write,
    input wire logic [2:0]                o_last_address,
    input wire logic [`SSP_CNT_W-1:0]     o_word_count,
    input wire logic [10:0]               o_main_integer_divider,
    input wire logic                      o_main_synth_powerdown,
    input wire logic                      o_aux_synth_powerdown,
    input wire logic                      o_auto_powerup_on_divider_write,
    input wire ssp_word_t [`SSP_NUM_LATCH-1:0] o_latch_bank
);
    default clocking dc @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    ce_low_down_a: assert property (
        !i_chip_enable [*5] |-> o_main_powered_down && o_aux_powered_down)
        else $error("section powered with chip enable low");
    both_up_a: assert property (
        i_chip_enable [*5] ##0 !o_main_synth_powerdown && !o_aux_synth_powerdown
        |-> !o_main_powered_down && !o_aux_powered_down)
        else $error("section down with both bits clear");
    aux_follow_a: assert property (
        i_chip_enable [*5] |-> o_aux_powered_down == o_aux_synth_powerdown)
        else $error("aux power state differs from its bit");
    main_down_a: assert property (
        i_chip_enable [*5] ##0 o_latch_write[1] && o_main_synth_powerdown
        |-> o_main_powered_down)
        else $error("main not down after its bit was set");
    auto_up_a: assert property (
        i_chip_enable [*5] ##0 o_latch_write[0] && o_auto_powerup_on_divider_write
        |-> !o_main_powered_down)
        else $error("main not up after divider write");
    clear_pair_a: assert property (
        o_lock_detect_clear == o_latch_write[0] && o_fastlock_clear == o_latch_write[0])
        else $error("counter clears differ from divider write");
    write_pulse_a: assert property (
        |o_latch_write |-> $onehot(o_latch_write) ##1 o_latch_write == '0)
        else $error("latch write pulse not one-hot single cycle");
    last_addr_a: assert property (
        |o_latch_write |-> o_latch_write[o_last_address]
        && o_word_count == 16'($past(o_word_count) + 16'h1))
        else $error("address or count wrong on write");
    bank_hold_a: assert property (
        o_latch_write == '0 |-> $stable(o_latch_bank))
        else $error("latch changed without a write");
    div_field_a: assert property (
        o_main_integer_divider == o_latch_bank[0][23:13])
        else $error("integer divider field misplaced");
endmodule : ssp_props

bind ssp_top ssp_props u_props (
    .i_clk, .i_arst_n, .i_chip_enable, .o_main_powered_down, .o_aux_powered_down,
    .o_lock_detect_clear, .o_fastlock_clear, .o_latch_write, .o_last_address,
    .o_word_count, .o_main_integer_divider, .o_main_synth_powerdown,
    .o_aux_synth_powerdown, .o_auto_powerup_on_divider_write, .o_latch_bank
);
`default_nettype wire

/* File: ssp_host.sv */
// Host model driving the three-wire programming link
`timescale 1ns/100ps
`default_nettype none
`include "ssp_defines.svh"
module ssp_host
    import ssp_pkg::*;
(
    // Link pins toward the device
    output logic o_sclk,
    output logic o_sdata,
    output logic o_strobe
);
    initial begin
        o_sclk = 1'b0;
        o_sdata = 1'b0;
        o_strobe = 1'b0;
    end
    // Clock stands still between frames; data flips so it never looks held
    task automatic shift(input ssp_word_t w, input int n);
        // Offset keeps link edges off core clock edges
        #2;
        for (int i = n - 1; i >= 0; i--) begin
            o_sdata = w[i];
            #15 o_sclk = 1'b1;
            #15 o_sclk = 1'b0;
        end
        o_sdata = ~o_sdata;
    endtask : shift
    // Strobe held several core cycles so the word crosses quietly
    task automatic commit();
        #18 o_strobe = 1'b1;
        #60 o_strobe = 1'b0;
        #40;
    endtask : commit
endmodule : ssp_host
`default_nettype wire

/* File: tb_synth_serial_program_powerdown.sv */
// Self-checking bench for the serial programming front end
`timescale 1ns/100ps
`default_nettype none
`include "ssp_defines.svh"
module tb_synth_serial_program_powerdown
    import ssp_pkg::*;
();
    logic                           i_clk = 1'b0;
    logic                           i_arst_n = 1'b0;
    logic                           i_chip_enable = 1'b0;
    logic                           sclk, sdata, strobe, main_pd, aux_pd;
    logic [`SSP_NUM_LATCH-1:0]      written, exp_written;
    logic [2:0]                     last_addr;
    logic [`SSP_CNT_W-1:0]          count;
    logic [10:0]                    int_div;
    logic [11:0]                    frac_num;
    logic                           psel, aux_rst, main_rst, main_bit, aux_bit, auto_powerup_on_divider_write;
    logic [5:0]                     ref_div;
    logic [11:0]                    frac_den, aux_ref;
    logic [18:0]                    aux_n;
    logic [3:0]                     gain;
    logic [9:0]                     den_ext, num_ext;
    logic [13:0]                    toc;
    ssp_word_t [`SSP_NUM_LATCH-1:0] bank;
    ssp_word_t                      exp_bank [8];
    int                             mismatches = 0;
    int                             tests_run = 0;
    int unsigned                    exp_count = 0;

    always #5 i_clk = ~i_clk;

    ssp_host host (.o_sclk(sclk), .o_sdata(sdata), .o_strobe(strobe));
    ssp_top dut (
        .i_clk, .i_arst_n, .i_sclk(sclk), .i_sdata(sdata), .i_latch_strobe(strobe),
        .i_chip_enable, .o_main_powered_down(main_pd), .o_aux_powered_down(aux_pd),
        .o_lock_detect_clear(), .o_fastlock_clear(), .o_latch_write(),
        .o_latch_written(written), .o_last_address(last_addr), .o_word_count(count),
        .o_main_integer_divider(int_div), .o_main_frac_numerator(frac_num),
        .o_main_synth_powerdown(main_bit), .o_main_prescaler_select(psel),
        .o_main_reference_divider(ref_div), .o_main_frac_denominator(frac_den),
        .o_aux_synth_powerdown(aux_bit), .o_aux_integer_divider(aux_n),
        .o_main_pump_gain(gain),
        .o_aux_reference_divider(aux_ref), .o_auto_powerup_on_divider_write(auto_powerup_on_divider_write),
        .o_main_frac_denominator_ext(den_ext), .o_main_frac_numerator_ext(num_ext),
        .o_fastlock_timeout_count(toc), .o_aux_counter_reset(aux_rst),
        .o_main_counter_reset(main_rst),
        .o_latch_bank(bank)
    );

    task automatic chk(input string what, input ssp_word_t seen, input ssp_word_t exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run

    // Target latch of a word, -1 for the unmapped code
    function automatic int idx_of(input ssp_word_t w);
        return w[0] ? ((w[3:1] == 3'h0) ? -1 : int'(w[3:1])) : 0;
    endfunction : idx_of

    task automatic wr(input ssp_word_t w);
        int k;
        k = idx_of(w);
        host.shift(w, 24);
        host.commit();
        repeat (6) @(negedge i_clk);
        if (k >= 0) begin
            exp_bank[k] = w;
            exp_written[k] = 1'b1;
            exp_count++;
            chk("last address", 24'(last_addr), 24'(k));
        end
        for (int i = 0; i < 8; i++)
            chk("latch word", bank[i], exp_bank[i]);
        chk("word count", 24'(count), 24'(exp_count));
        chk("written flags", 24'(written), 24'(exp_written));
    endtask : wr

    task automatic pw(input logic m, input logic a);
        chk("main down", 24'(main_pd), 24'(m));
        chk("aux down", 24'(aux_pd), 24'(a));
    endtask : pw

    // Field outputs against their mapped bit ranges
    task automatic fields();
        chk("prescaler select", 24'(psel), 24'(exp_bank[1][22]));
        chk("reference divider", 24'(ref_div), 24'(exp_bank[1][21:16]));
        chk("frac denominator", 24'(frac_den), 24'(exp_bank[1][15:4]));
        chk("aux divider", 24'(aux_n), 24'(exp_bank[2][22:4]));
        chk("pump gain", 24'(gain), 24'(exp_bank[3][19:16]));
        chk("aux reference", 24'(aux_ref), 24'(exp_bank[3][15:4]));
        chk("denominator ext", 24'(den_ext), 24'(exp_bank[5][23:14]));
        chk("numerator ext", 24'(num_ext), 24'(exp_bank[5][13:4]));
        chk("timeout count", 24'(toc), 24'(exp_bank[6][17:4]));
        chk("counter resets", 24'({aux_rst, main_rst}), 24'(exp_bank[7][7:6]));
        chk("main pd bit", 24'(main_bit), 24'(exp_bank[1][23]));
        chk("aux pd bit", 24'(aux_bit), 24'(exp_bank[2][23]));
        chk("auto power-up bit", 24'(auto_powerup_on_divider_write), 24'(exp_bank[4][23]));
    endtask : fields

    initial begin
        #300us;
        mismatches++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h79FA6894));
        for (int i = 0; i < 8; i++)
            exp_bank[i] = '0;
        exp_written = '0;
        repeat (3) @(negedge i_clk);
        i_arst_n = 1'b1;
        repeat (4) @(negedge i_clk);
        pw(1'b1, 1'b1);
        for (int r = 0; r < 3; r++)
            for (int a = 0; a < 8; a++)
                wr(a == 0 ? {23'($urandom), 1'b0} : {20'($urandom), 3'(a), 1'b1});
        chk("integer divider", 24'(int_div), 24'(exp_bank[0][23:13]));
        chk("frac numerator", 24'(frac_num), 24'(exp_bank[0][12:1]));
        fields();
        $display("done: address decode");
        wr({20'($urandom), 4'h1});
        host.shift(24'($urandom), 10);
        wr({20'($urandom), 4'hB});
        $display("done: refused and partial words");
        i_chip_enable = 1'b1;
        wr(24'h000003);
        wr(24'h000005);
        wr({20'($urandom), 4'h7});
        wr(24'h20C709);
        wr({23'($urandom), 1'b0});
        pw(1'b0, 1'b0);
        wr(24'h800003);
        pw(1'b1, 1'b0);
        wr(24'h800005);
        pw(1'b1, 1'b1);
        wr(24'hA0C709);
        wr({23'($urandom), 1'b0});
        pw(1'b0, 1'b1);
        i_chip_enable = 1'b0;
        repeat (6) @(negedge i_clk);
        pw(1'b1, 1'b1);
        i_chip_enable = 1'b1;
        repeat (6) @(negedge i_clk);
        pw(1'b1, 1'b1);
        fields();
        $display("done: power control");
        complete_run();
    end
endmodule : tb_synth_serial_program_powerdown
`default_nettype wire
